// >>> design/vid_ctl.sv
`timescale 1ns/10ps
`include "vid_ctl_params.svh"
module vid_ctl #(
  parameter int unsigned         UPDATE_CYCLES = `VID_UPDATE_CYCLES,
  parameter vid_ctl_pkg::serial_role_e ROLE    = vid_ctl_pkg::serial_master_e
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire vid_ctl_pkg::code_t target_code,
  input  wire logic              temp_below_zero,
  input  wire logic              vid_ack,
  input  wire logic              bus_busy,
  output vid_ctl_pkg::code_t     vid_code,
  output logic                   vid_code_oe,
  output logic                   vid_buf_en,
  output logic                   vid_code_avail,
  output vid_ctl_pkg::code_req_s serial_req
);
  import vid_ctl_pkg::*;

  typedef enum logic [1:0] {init_e, drive_e, run_e} phase_e;

  // ==========================================================
  // constants
  // header values are pinned to the width they meet, so no compare, add
  // or load below is silently widened or cut
  localparam code_t                   DEFAULT_CODE = code_t'(`VID_DEFAULT_CODE);
  localparam code_t                   MIN_CODE     = code_t'(`VID_MIN_CODE);
  localparam code_t                   STEP_CODE    = code_t'(`VID_STEP);
  localparam logic [4:0]              INIT_LAST    = 5'(`VID_INIT_CYCLES - 1);
  localparam logic [`VID_TIMER_W-1:0] GAP_LOAD     = `VID_TIMER_W'(UPDATE_CYCLES - 1);
  localparam logic [`VID_TIMER_W-1:0] TIMER_ONE    = `VID_TIMER_W'(1);

  // ==========================================================
  // internal state and decode
  phase_e                  phase_reg;
  logic [4:0]              init_cnt_reg;
  logic [`VID_TIMER_W-1:0] timer_reg;
  code_t                   code_reg;
  code_t                   goal;
  code_t                   code_next;
  logic                    target_in_range;
  logic                    step_down;
  logic                    step_up;
  logic                    ack_taken;
  logic                    bus_blocked;
  logic                    drive_phase;
  logic                    run_phase;
  logic                    timer_idle;
  logic                    may_update;

  // ==========================================================
  // initialization sequencing
  // the regulator boots on the bias default, so nothing is driven until
  // the init count has run out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg    <= init_e;
      init_cnt_reg <= 5'h00;
    end else begin
      unique case (phase_reg)
        init_e: begin
          if (init_cnt_reg == INIT_LAST) begin
            phase_reg <= drive_e;
          end else begin
            init_cnt_reg <= init_cnt_reg + 5'h01;
          end
        end
        drive_e: phase_reg <= run_e;
        run_e:   phase_reg <= run_e;
        default: phase_reg <= init_e;
      endcase
    end
  end

  assign drive_phase = (phase_reg == drive_e);
  assign run_phase   = (phase_reg == run_e);

  // ==========================================================
  // pin driver and buffer enable
  // drivers come on one cycle before the buffer enable so the bias default
  // is only overridden by a code already stable on the lines
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vid_code_oe <= 1'b0;
    end else begin
      vid_code_oe <= (phase_reg != init_e);
    end
  end

  // both enables stay up until the next reset; a mid-run reset hands the
  // lines back to the bias network at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vid_buf_en <= 1'b0;
    end else begin
      vid_buf_en <= run_phase;
    end
  end

  // ==========================================================
  // goal selection
  // cold die or out-of-range targets fall back to the boot level; the
  // ceiling is the default, so the code never asks for more than boot
  assign target_in_range = (target_code >= MIN_CODE) && (target_code <= DEFAULT_CODE);

  always_comb begin
    if (temp_below_zero) begin
      goal = DEFAULT_CODE;
    end else if (!target_in_range) begin
      goal = DEFAULT_CODE;
    end else begin
      goal = {target_code[`VID_CODE_W-1:1], 1'b0};
    end
  end

  // ==========================================================
  // single-step move toward the goal
  // goal and code are both even, so one step never overshoots
  assign step_down = (goal < code_reg);
  assign step_up   = (goal > code_reg);

  always_comb begin
    if (step_down) begin
      code_next = code_reg - STEP_CODE;
    end else if (step_up) begin
      code_next = code_reg + STEP_CODE;
    end else begin
      code_next = code_reg;
    end
  end

  // ==========================================================
  // update gating
  // the pacing timer only starts counting once the ack has been seen,
  // so a slow consumer never shortens the gap between codes
  assign ack_taken   = vid_code_avail && vid_ack;
  assign bus_blocked = (ROLE == serial_master_e) && bus_busy;
  assign timer_idle  = (timer_reg == '0);
  assign may_update  = run_phase && !vid_code_avail && timer_idle &&
                       (step_down || step_up) && !bus_blocked;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_reg <= DEFAULT_CODE;
    end else if (may_update) begin
      code_reg <= code_next;
    end
  end

  // a blocked bus only delays the next code; the gap is never shortened
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_reg <= '0;
    end else if (ack_taken) begin
      timer_reg <= GAP_LOAD;
    end else if (!timer_idle) begin
      timer_reg <= timer_reg - TIMER_ONE;
    end
  end

  // ==========================================================
  // consumer handshake; first presentation is the default code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vid_code_avail <= 1'b0;
    end else if (drive_phase) begin
      vid_code_avail <= 1'b1;
    end else if (may_update) begin
      vid_code_avail <= 1'b1;
    end else if (ack_taken) begin
      vid_code_avail <= 1'b0;
    end
  end

  // presented code only moves together with a fresh available flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vid_code <= DEFAULT_CODE;
    end else if (may_update) begin
      vid_code <= code_next;
    end
  end

  // ==========================================================
  // serial hand-off: a slave build never requests bus writes
  // the request is a one-cycle pulse; the bus engine must latch the code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_req <= '{valid: 1'b0, code: DEFAULT_CODE};
    end else begin
      serial_req.valid <= (ROLE == serial_master_e) &&
                          (may_update || drive_phase);
      if (may_update) begin
        serial_req.code <= code_next;
      end
    end
  end
endmodule

// >>> design/vid_ctl_params.svh
`ifndef VID_CTL_PARAMS_SVH
`define VID_CTL_PARAMS_SVH

// code weight 5 mV, default 0.9 V = 180, limits 0.83 V = 166, 0.95 V = 190
`define VID_CODE_W        8
`define VID_DEFAULT_CODE  8'hb4
`define VID_MIN_CODE      8'ha6
`define VID_MAX_CODE      8'hbe
`define VID_STEP          8'h02
`define VID_CLK_NS        5
`define VID_UPDATE_MS     10
`define VID_UPDATE_CYCLES ((`VID_UPDATE_MS * 1000000) / `VID_CLK_NS)
`define VID_INIT_CYCLES   16
`define VID_TIMER_W       24
`endif

// >>> design/vid_ctl_pkg.sv
`include "vid_ctl_params.svh"
package vid_ctl_pkg;
  typedef logic [`VID_CODE_W-1:0] code_t;
  typedef enum logic {serial_slave_e, serial_master_e} serial_role_e;
  typedef struct packed {
    logic  valid;
    code_t code;
  } code_req_s;
endpackage

// >>> tb/vid_ctl_sva.sv
`timescale 1ns/10ps
module vid_ctl_sva import vid_ctl_pkg::*; (
  input wire logic      clk,
  input wire logic      reset_n,
  input wire logic      temp_below_zero,
  input wire logic      vid_ack,
  input wire code_t     vid_code,
  input wire logic      vid_code_oe,
  input wire logic      vid_buf_en,
  input wire logic      vid_code_avail,
  input wire code_req_s serial_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==== checks
  sequence s_drive; vid_code == 8'hb4 && !vid_buf_en ##1 vid_buf_en; endsequence
  property p_hold; vid_code_avail && !vid_ack |=> $stable(vid_code) && vid_code_avail; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_gap; vid_code_avail && vid_ack |=> !vid_code_avail [*8]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_step; $changed(vid_code) |-> 8'(vid_code - $past(vid_code)) inside {8'h02, 8'hfe}; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_boot; $rose(vid_code_oe) |-> s_drive; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_ser; $changed(vid_code) |-> serial_req.valid && serial_req.code == vid_code; endproperty
  a_ser: assert property (p_ser) else $error("serial");
  property p_rst; $rose(reset_n) |-> vid_code == 8'hb4 && !vid_code_oe && !vid_code_avail; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_cold; $changed(vid_code) && temp_below_zero && $past(temp_below_zero, 24) |-> vid_code > $past(vid_code);
  endproperty
  a_cold: assert property (p_cold) else $error("cold");
  property p_range; !vid_code[0] && vid_code >= 8'ha6 && vid_code <= 8'hb4; endproperty
  a_range: assert property (p_range) else $error("range");
endmodule
bind vid_ctl vid_ctl_sva u_vid_ctl_sva (.clk, .reset_n, .temp_below_zero, .vid_ack, .vid_code, .vid_code_oe,
  .vid_buf_en, .vid_code_avail, .serial_req);

// >>> tb/vid_reg_model.sv
`timescale 1ns/10ps
module vid_reg_model import vid_ctl_pkg::*; (
  input wire logic  clk,
  input var int     dly,
  input wire code_t code,
  input wire logic  buf_en,
  input wire logic  avail,
  output logic      ack = 1'b0,
  output int        mv = 900
);
  int n = 0;
  // acks after dly cycles of avail, so a slow consumer is modelled too
  always @(posedge clk) begin
    ack <= avail && !ack && n >= dly;
    n <= avail ? n + 1 : 0;
    mv <= buf_en ? code * 5 : 900;
  end
endmodule

// >>> tb/voltage_id_code_controller_test.sv
`timescale 1ns/10ps
module voltage_id_code_controller_test;
  import vid_ctl_pkg::*;
  logic      clk = 0, reset_n = 0, temp_below_zero = 0, bus_busy = 0, vid_ack;
  logic      vid_code_oe, vid_buf_en, vid_code_avail;
  code_t     target_code = 8'hb4, vid_code;
  code_req_s serial_req;
  int        fail_count = 0, checks = 0, dly = 1, mv;
  code_t     rows [4][2] = '{'{8'ha6, 8'ha6}, '{8'hb3, 8'hb2}, '{8'hc0, 8'hb4}, '{8'ha0, 8'hb4}};
  initial forever #2.5 clk = ~clk;
  vid_ctl #(.UPDATE_CYCLES(20)) u_vid_ctl (.clk, .reset_n, .target_code, .temp_below_zero, .vid_ack, .bus_busy,
    .vid_code, .vid_code_oe, .vid_buf_en, .vid_code_avail, .serial_req);
  vid_reg_model u_vid_reg_model (.clk, .dly, .code(vid_code), .buf_en(vid_buf_en), .avail(vid_code_avail),
    .ack(vid_ack), .mv);
  task cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (e !== g) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task go(code_t e);
    for (int i = 0; i < 400 && vid_code !== e; i++) @(posedge clk);
    repeat (60) @(posedge clk);
    cmp("code", e, vid_code);
  endtask
  task final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==== watchdog
  // run needs about 2000 cycles; 10000 leaves room for slow acks
  initial begin
    #50000;
    fail_count++;
    final_report;
  end
  // ==== sequence
  initial begin
    repeat (20) @(posedge clk);
    cmp("rst", 9'h0b4, {vid_code_oe, vid_code});
    reset_n <= 1;
    go(8'hb4);
    cmp("boot", 900, mv);
    foreach (rows[i]) begin
      target_code <= rows[i][0];
      go(rows[i][1]);
      cmp("mv", rows[i][1] * 5, mv);
    end
    dly <= 200;
    target_code <= 8'ha6;
    repeat (150) @(posedge clk);
    cmp("hold", 9'h1b2, {vid_code_avail, vid_code});
    dly <= 1;
    go(8'ha6);
    temp_below_zero <= 1;
    go(8'hb4);
    temp_below_zero <= 0;
    bus_busy <= 1;
    repeat (100) @(posedge clk);
    cmp("busy", 8'hb4, vid_code);
    bus_busy <= 0;
    go(8'ha6);
    reset_n <= 0;
    repeat (3) @(posedge clk);
    cmp("rst2", 10'h0b4, {vid_code_avail, vid_code_oe, vid_code});
    reset_n <= 1;
    repeat (2) @(posedge clk);
    cmp("rst2_oe", 2'h0, {vid_code_oe, vid_buf_en});
    go(8'ha6);
    cmp("mv2", 830, mv);
    final_report;
  end
endmodule
